/* hw/dsc_core.sv */
// Summary of operation
// - calendar keeps running in deep sleep; its alarm may wake the device
// - config bit 1 picks calendar clock: internal rc or secondary oscillator
// - any wake causes a full power-on reset then reset vector fetch
// - device sets exit flag on wake; firmware reads then clears it
// - fault seen in deep sleep sets fault flag and wakes with reset
// - fault watch always active in deep sleep, no enable needed
// - select bit 7 chooses deep or ordinary sleep; resets to zero
// - high bit 1 enables ultra-low-power wake module in deep sleep
// - high bit 0 set blocks calendar alarm wake
// - low bit 2 disables ulp wake; ulp wakes only if clear and enabled
// - brown-out flag set when monitor enabled and supply dipped, not tripped
// - pins hold state after wake until release bit cleared, except after an mclr wake or an enabled brown-out trip in sleep
// - brown-out flag and release bit zero at power up; bits 7..3 zero
// - persistent bytes retain contents through deep sleep and wake
// - persistent bytes lost only on brown-out or supply collapse
// - select bit self-clears two instruction cycles after set
// - entry clears wake status; only first wake source is logged
// - wake before full entry not logged; entry aborted
//
// Purpose: deep sleep entry, wake logging, pin hold and persistent storage
// Assumes: i_rst_b is the always-on power-up reset; i_instr_tick marks an instruction cycle
// Notes: byte address of a register is four times its index
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_core (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [13:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [13:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_instr_tick,
    input wire logic i_sleep_instr,
    input wire logic i_calendar_alarm,
    input wire logic i_ulp_event,
    input wire logic i_watchdog_timeout,
    input wire logic i_mclr_event,
    input wire logic i_fault_detect,
    input wire logic i_bor_armed_dip,
    input wire logic i_bor_tripped,
    input wire logic i_core_brownout,
    output logic o_core_reset,
    output logic o_deep_sleep,
    output logic o_ordinary_sleep,
    output logic o_sleep_abort,
    output logic o_pin_hold,
    output logic o_calendar_run,
    output logic o_calendar_source_select,
    output logic o_ulp_module_on
);
    typedef struct packed {
        dsc_pkg::dsc_state_e st;
        logic sel;
        logic [1:0] sel_age;
        logic ulp_en;
        logic cal_wdis;
        logic ulp_wdis;
        logic bor_flag;
        logic release_hold;
        logic [7:0] wake_low;
        logic wake_external_interrupt_zero;
        logic exit_flag;
        logic reg_slp;
        logic idle_en;
        logic cal_src;
        logic bor_en;
        logic cal_sync;
        logic [15:0] pbytes;
        logic abort;
        logic slp;
    } dsc_core_s;
    dsc_core_s q_r, q_nxt;
    dsc_bus_if bus ();

    // the select lifetime must fit the two-bit age counter
    if (`DSC_SELECT_LIFE_CYC < 1 || `DSC_SELECT_LIFE_CYC > 4) begin : g_life_chk
        $error("select lifetime does not fit the age counter");
    end

    dsc_axil u_axil (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .bus(bus)
    );

    logic wr_lo, wr_hi, wr_p0, wr_p1, wr_wk, wr_cc, wr_cfg;
    logic cal_wake, ulp_wake, any_wake;
    logic [7:0] wb;

    assign wb = bus.wdata[7:0];
    assign wr_lo = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_CTRL_LOW;
    assign wr_hi = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_CTRL_HIGH;
    assign wr_p0 = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_PBYTE0;
    assign wr_p1 = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_PBYTE1;
    assign wr_wk = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_WAKE_LOW;
    assign wr_cc = bus.wr && bus.idx == `DSC_IDX_CORE_CTRL;
    assign wr_cfg = bus.wr && bus.wstrb[0] && bus.idx == `DSC_IDX_CONFIG;

    // gated wake sources
    assign cal_wake = i_calendar_alarm && !q_r.cal_wdis;
    assign ulp_wake = i_ulp_event && q_r.ulp_en && !q_r.ulp_wdis;
    assign any_wake = cal_wake || ulp_wake || i_watchdog_timeout || i_mclr_event
                      || i_fault_detect;

    // read mux, unimplemented bits read zero
    always_comb begin
        bus.hit = 1'b1;
        bus.rdata = 32'h0;
        case (bus.idx)
            `DSC_IDX_CTRL_LOW: begin
                bus.rdata[`DSC_LO_ULP_WDIS] = q_r.ulp_wdis;
                bus.rdata[`DSC_LO_BOR_FLAG] = q_r.bor_flag;
                bus.rdata[`DSC_LO_RELEASE] = q_r.release_hold;
            end
            `DSC_IDX_CTRL_HIGH: begin
                bus.rdata[`DSC_HI_SELECT] = q_r.sel;
                bus.rdata[`DSC_HI_ULP_EN] = q_r.ulp_en;
                bus.rdata[`DSC_HI_CAL_WDIS] = q_r.cal_wdis;
            end
            `DSC_IDX_PBYTE0: bus.rdata[7:0] = q_r.pbytes[7:0];
            `DSC_IDX_PBYTE1: bus.rdata[7:0] = q_r.pbytes[15:8];
            `DSC_IDX_WAKE_LOW: bus.rdata[7:0] = q_r.wake_low;
            `DSC_IDX_WAKE_HIGH: bus.rdata[0] = q_r.wake_external_interrupt_zero;
            `DSC_IDX_CORE_CTRL: begin
                bus.rdata[`DSC_CC_REG_SLP] = q_r.reg_slp;
                bus.rdata[`DSC_CC_EXIT] = q_r.exit_flag;
                bus.rdata[`DSC_CC_IDLE] = q_r.idle_en;
            end
            `DSC_IDX_CONFIG: begin
                bus.rdata[`DSC_CFG_CAL_SRC] = q_r.cal_src;
                bus.rdata[`DSC_CFG_BOR_EN] = q_r.bor_en;
                bus.rdata[`DSC_CFG_CAL_SYNC] = q_r.cal_sync;
            end
            default: bus.hit = 1'b0;
        endcase
    end

    // next state: register writes, entry, wake
    always_comb begin
        q_nxt = q_r;
        q_nxt.abort = 1'b0;
        q_nxt.slp = 1'b0;
        if (wr_hi) begin
            q_nxt.sel = wb[`DSC_HI_SELECT];
            q_nxt.sel_age = 2'h0;
            q_nxt.ulp_en = wb[`DSC_HI_ULP_EN];
            q_nxt.cal_wdis = wb[`DSC_HI_CAL_WDIS];
        end else if (q_r.sel && i_instr_tick) begin
            // short life guards against an accidental deep entry
            if (q_r.sel_age == 2'(`DSC_SELECT_LIFE_CYC - 1)) begin
                q_nxt.sel = 1'b0;
            end else begin
                q_nxt.sel_age = q_r.sel_age + 2'h1;
            end
        end
        if (wr_lo) begin
            q_nxt.ulp_wdis = wb[`DSC_LO_ULP_WDIS];
            q_nxt.bor_flag = wb[`DSC_LO_BOR_FLAG];
            q_nxt.release_hold = wb[`DSC_LO_RELEASE];
        end
        if (wr_p0) q_nxt.pbytes[7:0] = wb;
        if (wr_p1) q_nxt.pbytes[15:8] = wb;
        // unimplemented status bits 6 and 1 stay zero
        if (wr_wk) q_nxt.wake_low = wb & 8'hBD;
        if (wr_cc && bus.wstrb[0]) begin
            q_nxt.reg_slp = wb[`DSC_CC_REG_SLP];
            q_nxt.exit_flag = wb[`DSC_CC_EXIT];
        end
        if (wr_cc && bus.wstrb[1]) q_nxt.idle_en = bus.wdata[`DSC_CC_IDLE];
        if (wr_cfg) begin
            q_nxt.cal_src = wb[`DSC_CFG_CAL_SRC];
            q_nxt.bor_en = wb[`DSC_CFG_BOR_EN];
            q_nxt.cal_sync = wb[`DSC_CFG_CAL_SYNC];
        end
        // contents lost only on a core supply collapse while running or an enabled brown-out trip in sleep
        if (i_core_brownout && q_r.st == dsc_pkg::DSC_RUN) q_nxt.pbytes = 16'h0;
        if (i_bor_tripped && q_r.bor_en && q_r.st == dsc_pkg::DSC_SLEEP) begin
            q_nxt.pbytes = 16'h0;
            q_nxt.release_hold = 1'b0;
        end
        case (q_r.st)
            dsc_pkg::DSC_RUN: begin
                if (i_sleep_instr && q_r.sel && q_r.reg_slp && !q_r.idle_en) begin
                    q_nxt.st = dsc_pkg::DSC_ENTER;
                    q_nxt.sel = 1'b0;
                end else if (i_sleep_instr) begin
                    q_nxt.slp = 1'b1;
                end
            end
            dsc_pkg::DSC_ENTER: begin
                if (any_wake) begin
                    q_nxt.st = dsc_pkg::DSC_RUN;
                    q_nxt.abort = 1'b1;
                end else begin
                    q_nxt.st = dsc_pkg::DSC_SLEEP;
                    q_nxt.wake_low = 8'h0;
                    q_nxt.wake_external_interrupt_zero = 1'b0;
                    q_nxt.bor_flag = 1'b0;
                    q_nxt.release_hold = 1'b1;
                end
            end
            dsc_pkg::DSC_SLEEP: begin
                if (q_r.bor_en && i_bor_armed_dip && !i_bor_tripped) begin
                    q_nxt.bor_flag = 1'b1;
                end
                if (any_wake) begin
                    q_nxt.st = dsc_pkg::DSC_WAKE;
                    // priority picks a single logged source
                    if (i_fault_detect) q_nxt.wake_low[`DSC_WK_FAULT] = 1'b1;
                    else if (i_mclr_event) q_nxt.wake_low[`DSC_WK_MCLR] = 1'b1;
                    else if (cal_wake) q_nxt.wake_low[`DSC_WK_CAL] = 1'b1;
                    else if (i_watchdog_timeout) q_nxt.wake_low[`DSC_WK_WDT] = 1'b1;
                    else q_nxt.wake_low[`DSC_WK_ULP] = 1'b1;
                    if (i_mclr_event) q_nxt.release_hold = 1'b0;
                end
            end
            dsc_pkg::DSC_WAKE: begin
                // core reset pulse done, exit flag set, control bits except brown-out flag and release bit back to power-up values
                q_nxt.st = dsc_pkg::DSC_RUN;
                q_nxt.exit_flag = 1'b1;
                q_nxt.sel = 1'b0;
                q_nxt.ulp_en = 1'b0;
                q_nxt.cal_wdis = 1'b0;
                q_nxt.ulp_wdis = 1'b0;
                q_nxt.reg_slp = 1'b0;
                q_nxt.idle_en = 1'b0;
            end
            default: q_nxt.st = dsc_pkg::DSC_RUN;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q_r <= '0;
            q_r.wake_low <= `DSC_RST_WAKE_LOW;
        end else begin
            q_r <= q_nxt;
        end
    end

    // status outputs
    assign o_core_reset = q_r.st == dsc_pkg::DSC_WAKE;
    assign o_deep_sleep = q_r.st == dsc_pkg::DSC_SLEEP;
    assign o_ordinary_sleep = q_r.slp;
    assign o_sleep_abort = q_r.abort;
    assign o_pin_hold = q_r.release_hold;
    assign o_calendar_run = 1'b1;
    assign o_calendar_source_select = q_r.cal_src;
    assign o_ulp_module_on = q_r.ulp_en && q_r.st == dsc_pkg::DSC_SLEEP;
endmodule

/* hw/dsc_params.svh */
// Purpose: offsets, field positions, reset values and timing counts of the sleep controller
// Assumes: 32-bit axi4-lite register bus, one word per register
// Notes: offsets are word indexes; byte address is four times the index
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// printed offsets are not multiples of four: kept as indexes, byte address = 4 * index
`define DSC_IDX_CTRL_LOW 12'hF4C
`define DSC_IDX_CTRL_HIGH 12'hF4D
`define DSC_IDX_PBYTE0 12'hF4E
`define DSC_IDX_PBYTE1 12'hF4F
`define DSC_IDX_WAKE_LOW 12'hF4A
`define DSC_IDX_WAKE_HIGH 12'hF4B
`define DSC_IDX_CORE_CTRL 12'hF40
`define DSC_IDX_CONFIG 12'hF41

// sleep_control_high fields
`define DSC_HI_SELECT 7
`define DSC_HI_RSVD 2
`define DSC_HI_ULP_EN 1
`define DSC_HI_CAL_WDIS 0
// sleep_control_low fields
`define DSC_LO_ULP_WDIS 2
`define DSC_LO_BOR_FLAG 1
`define DSC_LO_RELEASE 0
// wake_source_low fields
`define DSC_WK_FAULT 7
`define DSC_WK_ULP 5
`define DSC_WK_WDT 4
`define DSC_WK_CAL 3
`define DSC_WK_MCLR 2
`define DSC_WK_POR 0
// core control word fields (regulator sleep, exit flag, idle enable)
`define DSC_CC_REG_SLP 7
`define DSC_CC_EXIT 3
`define DSC_CC_IDLE 8
// config word fields
`define DSC_CFG_CAL_SRC 1
`define DSC_CFG_BOR_EN 2
`define DSC_CFG_CAL_SYNC 4

`define DSC_RST_CTRL 8'h00
`define DSC_RST_WAKE_LOW 8'h01

// select bit clears two instruction cycles after set
`define DSC_SELECT_LIFE_CYC 2

`endif

/* hw/dsc_pkg.sv */
// Purpose: types of the sleep controller
// Assumes: nothing
// Notes: constants live in dsc_params.svh
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_RUN = 2'b00,
        DSC_ENTER = 2'b01,
        DSC_SLEEP = 2'b10,
        DSC_WAKE = 2'b11
    } dsc_state_e;
endpackage

/* hw/dsc_bus_if.sv */
// Purpose: register access strobes between the bus slave and the core
// Assumes: one access per cycle
// Notes: wr and rd are one-cycle pulses
`timescale 1ns/1ps
interface dsc_bus_if;
    logic wr;
    logic rd;
    logic [11:0] idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] rdata;
    logic hit;
    modport slave (output wr, output rd, output idx, output wdata, output wstrb,
                   input rdata, input hit);
    modport core (input wr, input rd, input idx, input wdata, input wstrb,
                  output rdata, output hit);
endinterface

/* hw/dsc_axil.sv */
// Purpose: axi4-lite slave that turns bus transfers into register strobes
// Assumes: address and data may arrive in either order
// Notes: unmapped index answers slverr, reads return zero
`timescale 1ns/1ps
module dsc_axil (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [13:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [13:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    dsc_bus_if.slave bus
);
    typedef struct packed {
        logic aw_ok;
        logic [11:0] aw_idx;
        logic w_ok;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } dsc_axil_s;
    dsc_axil_s q_r, q_nxt;
    logic do_wr, do_rd;

    // holding buffers free until the response leaves
    assign o_awready = !q_r.aw_ok && !q_r.bv;
    assign o_wready = !q_r.w_ok && !q_r.bv;
    // a write owns the shared index this cycle, so a read waits one cycle
    assign o_arready = !q_r.rv && !do_wr;
    assign do_wr = q_r.aw_ok && q_r.w_ok && !q_r.bv;
    assign do_rd = i_arvalid && !q_r.rv && !do_wr;
    assign bus.wr = do_wr;
    assign bus.rd = do_rd;
    assign bus.idx = do_wr ? q_r.aw_idx : i_araddr[13:2];
    assign bus.wdata = q_r.wd;
    assign bus.wstrb = q_r.ws;

    // channel bookkeeping, read answer one cycle after address
    always_comb begin
        q_nxt = q_r;
        if (i_awvalid && o_awready) begin
            q_nxt.aw_ok = 1'b1;
            q_nxt.aw_idx = i_awaddr[13:2];
        end
        if (i_wvalid && o_wready) begin
            q_nxt.w_ok = 1'b1;
            q_nxt.wd = i_wdata;
            q_nxt.ws = i_wstrb;
        end
        if (do_wr) begin
            q_nxt.aw_ok = 1'b0;
            q_nxt.w_ok = 1'b0;
            q_nxt.bv = 1'b1;
            q_nxt.br = bus.hit ? 2'h0 : 2'h2;
        end else if (q_r.bv && i_bready) begin
            q_nxt.bv = 1'b0;
        end
        if (do_rd) begin
            q_nxt.rv = 1'b1;
            q_nxt.rd = bus.hit ? bus.rdata : 32'h0;
            q_nxt.rr = bus.hit ? 2'h0 : 2'h2;
        end else if (q_r.rv && i_rready) begin
            q_nxt.rv = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_bvalid = q_r.bv;
    assign o_bresp = q_r.br;
    assign o_rvalid = q_r.rv;
    assign o_rdata = q_r.rd;
    assign o_rresp = q_r.rr;
endmodule

/* verification/dsc_core_assertions.sv */
// Purpose: port checks of the sleep controller
// Assumes: one clock domain, async active-low reset
// Notes: bound to dsc_core from the bench top file
`timescale 1ns/1ps
module dsc_core_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_bready,
    input wire logic i_rready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_sleep_instr,
    input wire logic i_fault_detect,
    input wire logic o_core_reset,
    input wire logic o_deep_sleep,
    input wire logic o_ordinary_sleep,
    input wire logic o_sleep_abort,
    input wire logic o_pin_hold,
    input wire logic o_calendar_run
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    // a wake is one reset pulse, never a stuck reset
    sequence s_wake;
        o_core_reset ##1 !o_core_reset;
    endsequence
    a_calendar_always_on: assert property (o_calendar_run)
        else $error("calendar clock stopped");
    a_fault_forces_wake: assert property (o_deep_sleep && i_fault_detect |-> ##[1:2] s_wake)
        else $error("fault in deep sleep gave no wake");
    a_exit_via_reset: assert property ($fell(o_deep_sleep) |-> ##[0:1] o_core_reset)
        else $error("deep sleep left without reset");
    a_pins_held_asleep: assert property (o_deep_sleep |-> o_pin_hold)
        else $error("pins not held in deep sleep");
    a_entry_after_instr: assert property ($rose(o_deep_sleep)
        |-> $past(i_sleep_instr, 2) || $past(i_sleep_instr))
        else $error("deep sleep without sleep instruction");
    a_abort_stays_awake: assert property (o_sleep_abort |-> !o_deep_sleep ##1 !o_deep_sleep)
        else $error("aborted entry still slept");
    a_ordinary_not_deep: assert property (o_ordinary_sleep |=> !o_deep_sleep [*2])
        else $error("ordinary sleep went deep");
    a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
endmodule

/* verification/dsc_core_tb.sv */
// Purpose: self-checking bench of the sleep controller
// Assumes: byte address is four times the register index
// Notes: wake sources driven as one vector, fault down to ulp
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_core_tb;
    logic i_core_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [13:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, rr;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic i_instr_tick, i_sleep_instr, i_bor_armed_dip, i_bor_tripped, i_core_brownout;
    logic [4:0] wk;
    logic o_core_reset, o_deep_sleep, o_ordinary_sleep, o_sleep_abort, o_pin_hold;
    logic o_calendar_run, o_calendar_source_select, o_ulp_module_on;
    int err_total, samples_checked, cyc, n_rst, n_ord, n_abt, seed;
    dsc_core dut_u (.i_core_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_instr_tick, .i_sleep_instr,
        .i_calendar_alarm(wk[2]), .i_ulp_event(wk[0]), .i_watchdog_timeout(wk[1]),
        .i_mclr_event(wk[3]), .i_fault_detect(wk[4]), .i_bor_armed_dip, .i_bor_tripped,
        .i_core_brownout, .o_core_reset, .o_deep_sleep, .o_ordinary_sleep, .o_sleep_abort,
        .o_pin_hold, .o_calendar_run, .o_calendar_source_select, .o_ulp_module_on);
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // pulse counters, so one-cycle outputs are never missed
    always @(posedge i_core_clk) begin
        cyc++;
        if (o_core_reset === 1'b1) n_rst++;
        if (o_ordinary_sleep === 1'b1) n_ord++;
        if (o_sleep_abort === 1'b1) n_abt++;
        if (cyc == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // both bytes strobed: the idle bit of core control sits in byte one
    task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge i_core_clk);
        i_awaddr <= {idx, 2'b00};
        i_wdata <= d;
        i_wstrb <= 4'h3;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        // no cycle count assumed: only the run timeout ends this wait
        do begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 1'b0;
        chk({30'h0, o_bresp}, {30'h0, er});
    endtask
    task automatic rdr(input logic [11:0] idx);
        @(posedge i_core_clk);
        i_araddr <= {idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        rd = o_rdata;
        rr = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
        rdr(idx);
        chk(rd, exp);
    endtask
    // select bit and sleep instruction back to back
    task automatic enter(input logic [7:0] hi);
        wr(`DSC_IDX_CORE_CTRL, 32'h80);
        do rdr(`DSC_IDX_CONFIG); while (rd[`DSC_CFG_CAL_SYNC] !== 1'b0);
        wr(`DSC_IDX_CTRL_HIGH, {24'h0, hi | 8'h80});
        @(posedge i_core_clk);
        i_sleep_instr <= 1'b1;
        @(posedge i_core_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic wake(input logic [4:0] src);
        int n, k;
        n = n_rst;
        wk <= src;
        for (k = 0; k < 20; k++) begin
            @(posedge i_core_clk);
            if (n_rst != n) break;
        end
        wk <= 5'h00;
        repeat (3) @(posedge i_core_clk);
        chk(n_rst, n + 1);
    endtask
    function automatic logic [31:0] wake_bits(input int i);
        case (i)
            0: return 32'h1 << `DSC_WK_FAULT;
            1: return 32'h1 << `DSC_WK_MCLR;
            2: return 32'h1 << `DSC_WK_CAL;
            3: return 32'h1 << `DSC_WK_WDT;
            default: return 32'h1 << `DSC_WK_ULP;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        int i, n;
        logic [31:0] v;
        logic [7:0] pb [2];
        seed = 32'h650A1252;
        {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = 64'h0;
        {i_instr_tick, i_sleep_instr, i_bor_armed_dip, i_bor_tripped, i_core_brownout} = 5'h00;
        wk = 5'h00;
        repeat (5) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        rc(`DSC_IDX_CTRL_LOW, 32'h0);
        rc(`DSC_IDX_CTRL_HIGH, 32'h0);
        chk(o_calendar_run, 32'h1);
        $display("reset test done");
        wr(`DSC_IDX_CTRL_LOW, 32'hFF);
        rc(`DSC_IDX_CTRL_LOW, 32'h07);
        wr(`DSC_IDX_CTRL_LOW, 32'h00);
        wr(`DSC_IDX_CTRL_HIGH, 32'hFB);
        rc(`DSC_IDX_CTRL_HIGH, 32'h83);
        // select ages out after two instruction cycles
        repeat (2) begin
            @(posedge i_core_clk);
            i_instr_tick <= 1'b1;
            @(posedge i_core_clk);
            i_instr_tick <= 1'b0;
        end
        rc(`DSC_IDX_CTRL_HIGH, 32'h03);
        n = n_ord;
        @(posedge i_core_clk);
        i_sleep_instr <= 1'b1;
        @(posedge i_core_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk(n_ord, n + 1);
        chk(o_deep_sleep, 32'h0);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            pb[i % 2] = v[7:0];
            wr(`DSC_IDX_PBYTE0 + 12'(i % 2), v);
            rc(`DSC_IDX_PBYTE0 + 12'(i % 2), {24'h0, v[7:0]});
        end
        wr(`DSC_IDX_CONFIG, 32'h02);
        chk(o_calendar_source_select, 32'h1);
        wr(`DSC_IDX_CONFIG, 32'h04);
        chk(o_calendar_source_select, 32'h0);
        rdr(12'h000);
        chk({rr, rd[29:0]}, 32'h80000000);
        wr(12'h000, 32'h5A, 2'h2);
        $display("register test done");
        for (i = 0; i < 5; i++) begin
            enter(8'h02);
            chk(o_deep_sleep & o_pin_hold & o_ulp_module_on, 32'h1);
            if (i == 3) begin
                i_bor_armed_dip <= 1'b1;
                @(posedge i_core_clk);
                i_bor_armed_dip <= 1'b0;
            end
            wake(5'h10 >> i);
            chk(o_pin_hold, i != 1);
            rdr(`DSC_IDX_CORE_CTRL);
            chk(rd[3], 32'h1);
            wr(`DSC_IDX_CORE_CTRL, 32'h0);
            rdr(`DSC_IDX_CORE_CTRL);
            chk(rd[3], 32'h0);
            rc(`DSC_IDX_WAKE_LOW, wake_bits(i));
            rc(`DSC_IDX_PBYTE0, {24'h0, pb[0]});
            rdr(`DSC_IDX_CTRL_LOW);
            chk(rd[1], i == 3);
            wr(`DSC_IDX_CTRL_LOW, 32'h0);
            chk(o_pin_hold, 32'h0);
        end
        $display("wake test done");
        // calendar and ulp blocked and give no wake; the fault then wakes
        wr(`DSC_IDX_CTRL_LOW, 32'h04);
        enter(8'h03);
        wk <= 5'h05;
        repeat (10) @(posedge i_core_clk);
        chk(o_deep_sleep, 32'h1);
        wake(5'h10);
        rc(`DSC_IDX_CORE_CTRL, 32'h08);
        wr(`DSC_IDX_CORE_CTRL, 32'h0);
        rc(`DSC_IDX_WAKE_LOW, 32'h80);
        wr(`DSC_IDX_CTRL_LOW, 32'h0);
        $display("blocked test done");
        n = n_abt;
        wk <= 5'h02;
        enter(8'h02);
        wk <= 5'h00;
        chk(n_abt, n + 1);
        chk(o_deep_sleep, 32'h0);
        rc(`DSC_IDX_WAKE_LOW, 32'h80);
        // core supply collapse while running wipes the persistent bytes
        i_core_brownout <= 1'b1;
        @(posedge i_core_clk);
        i_core_brownout <= 1'b0;
        rc(`DSC_IDX_PBYTE0, 32'h0);
        $display("abort test done");
        tally_and_finish();
    end
endmodule
bind dsc_core dsc_core_assertions chk_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_bready(i_bready), .i_rready(i_rready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_sleep_instr(i_sleep_instr),
    .i_fault_detect(i_fault_detect), .o_core_reset(o_core_reset), .o_deep_sleep(o_deep_sleep),
    .o_ordinary_sleep(o_ordinary_sleep), .o_sleep_abort(o_sleep_abort),
    .o_pin_hold(o_pin_hold), .o_calendar_run(o_calendar_run));
